// ---- dv/dfaig_chk.sv ----
// Port-level assertions for the DMA interrupt-request block.
`timescale 1ns/100ps
module dfaig_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [dfaig_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dfaig_pkg::DATA_W-1:0] pwdata,
    input wire logic [dfaig_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [dfaig_pkg::CH_N-1:0] xfer_req,
    input wire logic [dfaig_pkg::CH_N-1:0] xfer_go,
    input wire logic [dfaig_pkg::CH_N-1:0] end_irq_req,
    input wire logic [dfaig_pkg::CH_N-1:0] break_irq_req,
    input wire logic irq
);
    import dfaig_pkg::*;
    logic wc;
    // A control write landing at this edge; requests follow two edges on.
    assign wc = psel && penable && pwrite && ce && (paddr == OFF_CTRL);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_end0_rise: assert property (wc && pwdata[0] && !pwdata[4]
        |-> ##2 end_irq_req[0])
        else $error("end request 0 missing");
    a_brk0_rise: assert property (wc && pwdata[1] && !pwdata[5]
        |-> ##2 break_irq_req[0])
        else $error("break request 0 missing");
    a_end1_rise: assert property (wc && pwdata[2] && !pwdata[6] |-> ##2 end_irq_req[1])
        else $error("end request 1 missing");
    a_brk1_rise: assert property (wc && pwdata[3] && !pwdata[7] |-> ##2 break_irq_req[1])
        else $error("break request 1 missing");
    // A transfer in the write cycle may end the count, and that clear beats the write.
    a_end0_drop: assert property (wc && !xfer_go[0] && (!pwdata[0] || pwdata[4])
        |-> ##2 !end_irq_req[0])
        else $error("end request 0 not withdrawn");
    a_brk0_drop: assert property (wc && (!pwdata[1] || pwdata[5])
        |-> ##2 !break_irq_req[0])
        else $error("break request 0 not withdrawn");
    a_go_gated: assert property ((xfer_go & ~xfer_req) == 2'h0
        && (ce || xfer_go == 2'h0))
        else $error("transfer taken without request or clock enable");
    a_go_stops: assert property (wc && !(pwdata[4] && pwdata[5]) |-> ##1 !xfer_go[0])
        else $error("channel 0 ran while disabled");
    a_ready_zero: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_err_unmapped: assert property (psel && penable && paddr > OFF_IEN |-> pslverr)
        else $error("unmapped access without error");
    a_rd_zero: assert property (psel && penable && !pwrite &&
        (paddr > OFF_IEN || paddr == OFF_CLR) |-> prdata == 32'h0)
        else $error("unmapped or write-only read not zero");
    c_end_rise: cover property ($rose(end_irq_req[0]));
    c_brk_rise: cover property ($rose(break_irq_req[0]));
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule
bind dfaig_top dfaig_chk i_chk (.clk(clk), .arst_n(arst_n), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .xfer_req(xfer_req), .xfer_go(xfer_go), .end_irq_req(end_irq_req),
    .break_irq_req(break_irq_req), .irq(irq), .prdata(prdata));

// ---- dv/dfaig_src.sv ----
// Far-side model: transfer demand source and counter of channel 0 transfers taken.
`timescale 1ns/100ps
module dfaig_src (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [dfaig_pkg::CH_N-1:0] want,
    input wire logic [dfaig_pkg::CH_N-1:0] xfer_go,
    output logic [dfaig_pkg::CH_N-1:0] xfer_req,
    output logic [7:0] go_n0
);
    import dfaig_pkg::*;
    // Demand is a level held until the source is told to stop.
    assign xfer_req = want;
    // Counting here keeps the expectation apart from the block's own counter.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            go_n0 <= 8'h00;
        end else if (xfer_go[0]) begin
            go_n0 <= go_n0 + 8'h01;
        end
    end
endmodule

// ---- dv/test_dfaig_top.sv ----
// Self-checking bench for the DMA interrupt-request block.
`timescale 1ns/100ps
module test_dfaig_top;
    import dfaig_pkg::*;
    logic clk = 0;
    logic arst_n = 0;
    logic ce = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic nmi_pin = 0;
    logic err;
    logic pready, pslverr, irq;
    logic [7:0] paddr = 8'h00;
    logic [7:0] go_n0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic [1:0] want = 2'h0;
    logic [1:0] xfer_req, xfer_go, end_irq_req, break_irq_req;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    dfaig_top i_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xfer_req(xfer_req), .xfer_go(xfer_go),
        .nmi_pin(nmi_pin), .end_irq_req(end_irq_req), .break_irq_req(break_irq_req),
        .irq(irq));
    dfaig_src i_src (.clk(clk), .arst_n(arst_n), .want(want), .xfer_go(xfer_go),
        .xfer_req(xfer_req), .go_n0(go_n0));
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // A hang is cut short well past the roughly 125 cycles the tests need.
    always @(posedge clk) begin
        cyc++;
        if (cyc > 4000) begin
            bad_count++;
            report_and_stop;
        end
    end
    // One APB transfer; waits for ready rather than assuming zero wait states.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        bus(1'b0, OFF_CTRL, 32'h0);
        cmp(rd, 32'h0);
        // Each enable alone, with both channel enables low, raises one request.
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, OFF_CTRL, 32'h1 << i);
            wt(3);
            cmp({break_irq_req[1], end_irq_req[1], break_irq_req[0], end_irq_req[0]},
                32'h1 << i);
            bus(1'b0, OFF_CTRL, 32'h0);
            cmp(rd, 32'h1 << i);
        end
        bus(1'b1, OFF_IEN, 32'h1);
        bus(1'b1, OFF_CNT0, 32'h3);
        bus(1'b1, OFF_CTRL, 32'h1);
        @(posedge clk) want <= 2'b01;
        bus(1'b1, OFF_CTRL, 32'h31);
        wt(1);
        cmp(end_irq_req[0], 1'b0);
        wt(8);
        cmp(go_n0, 8'h03);
        cmp(end_irq_req[0], 1'b1);
        cmp(irq, 1'b1);
        bus(1'b1, OFF_IEN, 32'h0);
        wt(2);
        cmp(irq, 1'b0);
        bus(1'b0, OFF_STAT, 32'h0);
        cmp(rd, 32'h1);
        bus(1'b0, OFF_CNT0, 32'h0);
        cmp(rd, 32'h0);
        bus(1'b1, OFF_CLR, 32'h1);
        bus(1'b1, OFF_IEN, 32'h1);
        wt(2);
        cmp(irq, 1'b0);
        // Channel 0 in burst mode stops on the NMI; channel 1 keeps running.
        bus(1'b1, OFF_MODE, 32'h1);
        @(posedge clk) want <= 2'b10;
        bus(1'b1, OFF_CTRL, 32'hfa);
        wt(2);
        cmp(xfer_go, 2'b10);
        @(posedge clk) ce <= 1'b0;
        wt(1);
        cmp(xfer_go, 2'b00);
        @(posedge clk) ce <= 1'b1;
        @(posedge clk) nmi_pin <= 1'b1;
        @(posedge clk) nmi_pin <= 1'b0;
        wt(8);
        cmp(break_irq_req, 2'b01);
        bus(1'b0, OFF_CTRL, 32'h0);
        cmp(rd, 32'hda);
        bus(1'b0, OFF_STAT, 32'h0);
        cmp(rd, 32'h4);
        cmp(err, 1'b0);
        bus(1'b0, OFF_MODE, 32'h0);
        cmp(rd, 32'h1);
        bus(1'b0, OFF_IEN, 32'h0);
        cmp(rd, 32'h1);
        bus(1'b1, OFF_CTRL, 32'hfa);
        wt(3);
        cmp(break_irq_req[0], 1'b0);
        bus(1'b0, 8'h1c, 32'h0);
        cmp(err, 1'b1);
        cmp(rd, 32'h0);
        report_and_stop;
    end
endmodule

// ---- hdl/dfaig_pkg.sv ----
// Constants for the two-channel DMA interrupt-generation block.
package dfaig_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int CH_N = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CNT0 = 8'h04;
    localparam logic [7:0] OFF_CNT1 = 8'h08;
    localparam logic [7:0] OFF_MODE = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_CLR = 8'h14;
    localparam logic [7:0] OFF_IEN = 8'h18;

    // ------------------------------------------------------------------
    // Field positions of the control register
    // ------------------------------------------------------------------
    localparam int CTRL_END_EN_LSB = 0;
    localparam int CTRL_BRK_EN_LSB = 1;
    localparam int CTRL_TE_LSB = 4;
    localparam int CTRL_MTE_LSB = 5;
    localparam int CTRL_CH_STRIDE = 2;

    // ------------------------------------------------------------------
    // Field positions of the status, clear and enable registers
    // ------------------------------------------------------------------
    localparam int STAT_DONE_LSB = 0;
    localparam int STAT_NMI_LSB = 2;
    localparam int STAT_W = 4;

    // ------------------------------------------------------------------
    // Reset values and the last count value
    // ------------------------------------------------------------------
    localparam logic [1:0] BITS_RST = 2'h0;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_LAST = 16'h0001;
    localparam logic [3:0] STAT_RST = 4'h0;
    localparam logic [31:0] RDATA_RST = 32'h00000000;

endpackage

// ---- hdl/dfaig_top.sv ----
// Two-channel DMA enable, count and interrupt-request logic with an APB slave.
//
// Function
// R1 - Break enable and master off raise break
// R2 - Handler drops break by enable or restart
// R3 - End enable and transfer off raise end
// R4 - Handler drops end by enable or restart
// R5 - Bit 3 is channel 1 break enable
// R6 - Bit 2 is channel 1 end enable
// R7 - Bit 1 is channel 0 break enable
// R8 - Bit 0 is channel 0 end enable
// R9 - Requests run only with both enables set
// R10 - Transfer enable clears when count is exhausted
// R11 - NMI clears master enable in burst mode
// R12 - Request outputs are levels, drop next cycle
`timescale 1ns/100ps

// The block holds the per-channel interrupt enables and raises the end and
// break requests from them as levels. Around that core sit a transfer
// counter per channel, a stop of burst-mode channels on the NMI pin and a
// sticky status register with one interrupt line, all behind an APB slave.
// Addresses and sequencing live outside this block, so software must halt
// a channel before it rewrites the count of that channel.
module dfaig_top #(
    parameter int CNT_W = dfaig_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [dfaig_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dfaig_pkg::DATA_W-1:0] pwdata,
    output logic [dfaig_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [dfaig_pkg::CH_N-1:0] xfer_req,
    output logic [dfaig_pkg::CH_N-1:0] xfer_go,
    input wire logic nmi_pin,
    output logic [dfaig_pkg::CH_N-1:0] end_irq_req,
    output logic [dfaig_pkg::CH_N-1:0] break_irq_req,
    output logic irq
);
    import dfaig_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Software-visible enables, one bit per channel. The transfer enables
    // are also cleared by hardware, so they are not plain storage.
    logic [CH_N-1:0] end_irq_enable;
    logic [CH_N-1:0] break_irq_enable;
    logic [CH_N-1:0] channel_transfer_enable;
    logic [CH_N-1:0] master_transfer_enable;
    logic [CH_N-1:0] burst_mode;
    logic [CNT_W-1:0] xfer_cnt [CH_N];
    logic [STAT_W-1:0] irq_status;
    logic [STAT_W-1:0] irq_enable;
    // Pin synchroniser for the NMI input, and the flop behind it that keeps
    // the last synchronised level for edge detection.
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_s3;

    // Next values, all registered in one process, so the clock enable
    // covers every one of them.
    logic [CH_N-1:0] next_end_irq_enable;
    logic [CH_N-1:0] next_break_irq_enable;
    logic [CH_N-1:0] next_channel_transfer_enable;
    logic [CH_N-1:0] next_master_transfer_enable;
    logic [CH_N-1:0] next_burst_mode;
    logic [CNT_W-1:0] next_xfer_cnt [CH_N];
    logic [STAT_W-1:0] next_irq_status;
    logic [STAT_W-1:0] next_irq_enable;
    logic [DATA_W-1:0] next_prdata;
    logic [CH_N-1:0] next_end_irq_req;
    logic [CH_N-1:0] next_break_irq_req;
    logic next_irq;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic acc_wr;
    logic setup_rd;
    logic addr_hit;
    logic nmi_edge;
    logic [STAT_W-1:0] stat_set;
    logic [STAT_W-1:0] stat_clr;

    // Zero wait states: the read word is captured in the setup cycle, so the
    // access phase can finish at once while prdata still comes from a flop.
    assign pready = psel & penable;
    assign acc_wr = psel & penable & pwrite & ce;
    assign setup_rd = psel & ~penable & ~pwrite;

    // Only word-aligned offsets in the map answer without an error.
    always_comb begin
        unique case (paddr)
            OFF_CTRL, OFF_CNT0, OFF_CNT1, OFF_MODE, OFF_STAT, OFF_CLR, OFF_IEN: begin
                addr_hit = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // The error comes only with ready in the access phase, so a master
    // never sees it without a finished transfer.
    assign pslverr = psel & penable & ~addr_hit;

    // The third stage only feeds edge detection; the first stage is read
    // by the second alone. A pulse on the pin must cover a rising clock
    // edge with the clock enable high, or it is not seen at all.
    assign nmi_edge = nmi_s2 & ~nmi_s3;

    // A transfer runs only while both channel enables are set. The clock
    // enable gates the strobe too, so a frozen counter never misses a
    // transfer that the far side believes was taken.
    assign xfer_go = xfer_req & channel_transfer_enable & master_transfer_enable
        & {CH_N{ce}}; // see R9

    // ------------------------------------------------------------------
    // Channel control next state
    // ------------------------------------------------------------------
    // Hardware clears beat a software write in the same cycle, so a count
    // that runs out during a write still ends the transfer.
    always_comb begin
        next_end_irq_enable = end_irq_enable;
        next_break_irq_enable = break_irq_enable;
        next_channel_transfer_enable = channel_transfer_enable;
        next_master_transfer_enable = master_transfer_enable;
        next_burst_mode = burst_mode;
        stat_set = STAT_RST;
        // Status events are gathered here and merged with the clears in the
        // status process, where the set is given priority.
        for (int ch = 0; ch < CH_N; ch++) begin
            next_xfer_cnt[ch] = xfer_cnt[ch];
            if (acc_wr && paddr == OFF_CTRL) begin
                // Bits 3..0 hold break and end enables of channels 1 and 0.
                next_end_irq_enable[ch] =
                    pwdata[CTRL_END_EN_LSB + CTRL_CH_STRIDE * ch]; // see R6 see R8
                next_break_irq_enable[ch] =
                    pwdata[CTRL_BRK_EN_LSB + CTRL_CH_STRIDE * ch]; // see R5 see R7
                // Writing 0 to the transfer enable aborts the channel.
                next_channel_transfer_enable[ch] =
                    pwdata[CTRL_TE_LSB + CTRL_CH_STRIDE * ch]; // see R10 see R4
                next_master_transfer_enable[ch] =
                    pwdata[CTRL_MTE_LSB + CTRL_CH_STRIDE * ch]; // see R2
            end
            // The count registers sit one word apart, channel 0 first.
            if (acc_wr && paddr == (OFF_CNT0 + 8'(4 * ch))) begin
                next_xfer_cnt[ch] = pwdata[CNT_W-1:0];
            end
            // Burst mode only decides whether the NMI pin stops the channel.
            if (acc_wr && paddr == OFF_MODE) begin
                next_burst_mode[ch] = pwdata[ch];
            end
            // A count of zero runs the full range before it ends. A transfer
            // taken in the cycle of a count write wins and the write is lost.
            if (xfer_go[ch]) begin
                next_xfer_cnt[ch] = xfer_cnt[ch] - CNT_W'(1);
                if (xfer_cnt[ch] == CNT_W'(CNT_LAST)) begin
                    next_channel_transfer_enable[ch] = 1'b0; // see R10
                    stat_set[STAT_DONE_LSB + ch] = 1'b1;
                end
            end
            // NMI stops only channels in burst mode.
            if (nmi_edge && burst_mode[ch]) begin
                next_master_transfer_enable[ch] = 1'b0; // see R11
                stat_set[STAT_NMI_LSB + ch] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status next state
    // ------------------------------------------------------------------
    // A set in the same cycle as its clear survives, so no event is lost.
    always_comb begin
        stat_clr = STAT_RST;
        next_irq_enable = irq_enable;
        if (acc_wr && paddr == OFF_CLR) begin
            stat_clr = pwdata[STAT_W-1:0];
        end
        if (acc_wr && paddr == OFF_IEN) begin
            next_irq_enable = pwdata[STAT_W-1:0];
        end
        next_irq_status = (irq_status & ~stat_clr) | stat_set;
        // The line follows the next status and the next enables, so a write
        // to the enable register shows on it at the same edge.
        next_irq = |(next_irq_status & next_irq_enable);
    end

    // ------------------------------------------------------------------
    // Request outputs next state
    // ------------------------------------------------------------------
    // Requests follow the present enables, so they fall one cycle after the
    // handler clears an enable or restarts the channel. No status bit stands
    // behind them, so the handler removes the cause and not a flag.
    always_comb begin
        next_end_irq_req = end_irq_enable & ~channel_transfer_enable; // see R3 see R12 see R4
        next_break_irq_req = break_irq_enable & ~master_transfer_enable; // see R1 see R12 see R2
    end

    // ------------------------------------------------------------------
    // Read data next state
    // ------------------------------------------------------------------
    // The clear register is write-only and reads as zero. Capturing in the
    // setup cycle costs no wait state and keeps prdata steady through the
    // whole access phase.
    always_comb begin
        next_prdata = prdata;
        if (setup_rd) begin
            next_prdata = RDATA_RST;
            // Bits that a word does not use read as zero.
            unique case (paddr)
                OFF_CTRL: begin
                    for (int ch = 0; ch < CH_N; ch++) begin
                        next_prdata[CTRL_END_EN_LSB + CTRL_CH_STRIDE * ch] =
                            end_irq_enable[ch];
                        next_prdata[CTRL_BRK_EN_LSB + CTRL_CH_STRIDE * ch] =
                            break_irq_enable[ch];
                        next_prdata[CTRL_TE_LSB + CTRL_CH_STRIDE * ch] =
                            channel_transfer_enable[ch];
                        next_prdata[CTRL_MTE_LSB + CTRL_CH_STRIDE * ch] =
                            master_transfer_enable[ch];
                    end
                end
                OFF_CNT0: begin
                    next_prdata[CNT_W-1:0] = xfer_cnt[0];
                end
                OFF_CNT1: begin
                    next_prdata[CNT_W-1:0] = xfer_cnt[1];
                end
                OFF_MODE: begin
                    next_prdata[CH_N-1:0] = burst_mode;
                end
                OFF_STAT: begin
                    next_prdata[STAT_W-1:0] = irq_status;
                end
                OFF_IEN: begin
                    next_prdata[STAT_W-1:0] = irq_enable;
                end
                default: begin
                    next_prdata = RDATA_RST;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // The clock enable freezes every flop, the synchroniser included.
    // Reset loads constants only, so no data path reaches the reset tree.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            end_irq_enable <= BITS_RST;
            break_irq_enable <= BITS_RST;
            channel_transfer_enable <= BITS_RST;
            master_transfer_enable <= BITS_RST;
            burst_mode <= BITS_RST;
            for (int ch = 0; ch < CH_N; ch++) begin
                xfer_cnt[ch] <= CNT_W'(CNT_RST);
            end
            irq_status <= STAT_RST;
            irq_enable <= STAT_RST;
            prdata <= RDATA_RST;
            end_irq_req <= BITS_RST;
            break_irq_req <= BITS_RST;
            irq <= 1'b0;
            nmi_s1 <= 1'b0;
            nmi_s2 <= 1'b0;
            nmi_s3 <= 1'b0;
        end else if (ce) begin
            end_irq_enable <= next_end_irq_enable;
            break_irq_enable <= next_break_irq_enable;
            channel_transfer_enable <= next_channel_transfer_enable;
            master_transfer_enable <= next_master_transfer_enable;
            burst_mode <= next_burst_mode;
            for (int ch = 0; ch < CH_N; ch++) begin
                xfer_cnt[ch] <= next_xfer_cnt[ch];
            end
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            prdata <= next_prdata;
            end_irq_req <= next_end_irq_req;
            break_irq_req <= next_break_irq_req;
            irq <= next_irq;
            nmi_s1 <= nmi_pin;
            nmi_s2 <= nmi_s1;
            nmi_s3 <= nmi_s2;
        end
    end

endmodule
